// ==== hw/tas_flags.sv ====
// Status flags, masks and alarm outputs of the eight-channel monitor
//
// Functional notes
// - High-warning flag set when above high limit
// - Over-temperature flag set when above limit
// - Remote channel fault flag on open/short
// - Low-warning flag set when below low limit
// - Warning flags clear on read, reset later
// - Only temperature or limit change ends violation
// - Warning interrupt follows warning flags
// - High read or alert response releases interrupt
// - Release despite violation, reassert next conversion
// - Over flag holds until below limit minus 4
// - Over flag clears on raising limit 4 above
// - High register: ch7 bit7, local bit6
// - Over register: local bit7, ch7..1 below
// - Each remote compared to own limit
// - Host alert response receive byte, arbitration
// - Over output held until limit minus 4
// - Warning mask bit blocks channel interrupt
// - Over mask bit blocks channel output
`timescale 1ns/1ps
`default_nettype none
module tas_flags
  import tas_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Conversion results
  input wire logic convValid,
  input wire logic [2:0] convChan,
  input wire logic [7:0] convTemp,
  input wire logic convFault,
  // Limit registers, channel n in bits n*8+7..n*8
  input wire logic [63:0] hiLimit,
  input wire logic [63:0] loLimit,
  input wire logic [63:0] ovLimit,
  // Register port from the serial engine, on the link clock
  input wire logic linkClk,
  input wire logic [7:0] regAddr,
  input wire logic regWrStb,
  input wire logic [7:0] regWrData,
  input wire logic regRdStb,
  input wire logic araDone,
  output logic [7:0] regRdData,
  // Alarm pins
  output logic alertN,
  output logic overtN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rstS;
    logic [7:0] hi, lo, ov, flt, wMask, oMask;
    logic alert, alertN, overtN;
    logic [63:0] lastT, prevOvLim;
    logic [2:0] wrS, rdS, araS, ackS;
    logic wrSeen, rdSeen, araSeen;
    logic snapReq;
    logic [47:0] snap;
  } tas_core_t;

  typedef struct packed {
    logic [1:0] rstS;
    logic wrTgl, rdTgl, araTgl;
    logic [7:0] wrAddr, wrData, rdAddr;
    logic [2:0] reqS;
    logic ack;
    logic [47:0] snap;
    logic [7:0] rdData;
  } tas_link_t;

  localparam tas_core_t CORE_RST = '{alertN: 1'b1, overtN: 1'b1,
                                     default: '0};

  tas_core_t c, n;
  tas_link_t l, ln;
  logic rstSync, lrstSync;
  logic wrEv, rdEv, araEv, softEv, ackOk;
  logic chFaulty, hiViol, loViol, ovViol, ovRel;
  logic [2:0] hb, ob;
  logic [7:0] chHi, chLo, chOv;
  logic [5:0] sl;

  assign rstSync = c.rstS[1];
  assign lrstSync = l.rstS[1];

  // ----------------------------------------------------------------
  // Events from the link side, change taken once stages 2 and 3 agree
  // ----------------------------------------------------------------
  assign wrEv = (c.wrS[1] == c.wrS[2]) && (c.wrS[2] != c.wrSeen);
  assign rdEv = (c.rdS[1] == c.rdS[2]) && (c.rdS[2] != c.rdSeen);
  assign araEv = (c.araS[1] == c.araS[2]) && (c.araS[2] != c.araSeen);
  assign ackOk = (c.ackS[1] == c.ackS[2]) && (c.ackS[2] == c.snapReq);
  assign softEv = wrEv && (l.wrAddr == ADDR_CONFIG) &&
                  l.wrData[CFG_SWRST_BIT];

  // ----------------------------------------------------------------
  // Comparison of the current conversion
  // ----------------------------------------------------------------
  assign sl = {convChan, 3'b000};
  assign chHi = hiLimit[sl +: 8];
  assign chLo = loLimit[sl +: 8];
  assign chOv = ovLimit[sl +: 8];
  assign hb = hiPos(convChan);
  assign ob = ovPos(convChan);
  assign chFaulty = convFault && (convChan != CH_LOCAL);
  assign hiViol = convValid && !chFaulty && (convTemp > chHi);
  assign loViol = convValid && !chFaulty && (convTemp < chLo);
  assign ovViol = convValid && !chFaulty && (convTemp > chOv);
  assign ovRel = convValid && !chFaulty &&
                 (({1'b0, convTemp} + HYST_DEGC) < {1'b0, chOv});

  always_comb begin
    n = c;
    n.rstS = {c.rstS[0], 1'b1};
    n.wrS = {c.wrS[1:0], l.wrTgl};
    n.rdS = {c.rdS[1:0], l.rdTgl};
    n.araS = {c.araS[1:0], l.araTgl};
    n.ackS = {c.ackS[1:0], l.ack};
    if (wrEv) begin
      n.wrSeen = c.wrS[2];
    end
    if (rdEv) begin
      n.rdSeen = c.rdS[2];
    end
    if (araEv) begin
      n.araSeen = c.araS[2];
    end
    // A limit changed to at least the last temperature plus 4 releases a held over-temperature flag
    for (int i = 0; i < 8; i++) begin
      if ((ovLimit[i*8 +: 8] != c.prevOvLim[i*8 +: 8]) &&
          ({1'b0, ovLimit[i*8 +: 8]} >=
           ({1'b0, c.lastT[i*8 +: 8]} + HYST_DEGC))) begin
        n.ov[ovPos(i[2:0])] = 1'b0;
      end
    end
    n.prevOvLim = ovLimit;
    // Clears first, so a conversion in the same cycle wins
    if (rdEv && (l.rdAddr == ADDR_HIGH_WARN)) begin
      n.hi = REG_RESET;
      n.alert = 1'b0;
    end
    if (rdEv && (l.rdAddr == ADDR_LOW_WARN)) begin
      n.lo = REG_RESET;
    end
    if (araEv) begin
      n.alert = 1'b0;
    end
    if (wrEv && (l.wrAddr == ADDR_WARN_MASK)) begin
      n.wMask = l.wrData;
    end
    if (wrEv && (l.wrAddr == ADDR_OVT_MASK)) begin
      n.oMask = l.wrData;
    end
    if (convValid) begin
      n.lastT[sl +: 8] = convTemp;
      if (convChan != CH_LOCAL) begin
        n.flt[convChan - 3'h1] = convFault;
      end
      // A flag comes back each conversion until the violation ends
      if (hiViol) begin
        n.hi[hb] = 1'b1;
      end
      if (loViol) begin
        n.lo[hb] = 1'b1;
      end
      if ((hiViol || loViol) && !n.wMask[hb]) begin
        n.alert = 1'b1;
      end
      if (ovViol) begin
        n.ov[ob] = 1'b1;
      end else if (ovRel) begin
        n.ov[ob] = 1'b0;
      end
    end
    if (softEv) begin
      n.hi = REG_RESET;
      n.lo = REG_RESET;
      n.ov = REG_RESET;
      n.flt = REG_RESET;
      n.wMask = REG_RESET;
      n.oMask = REG_RESET;
      n.alert = 1'b0;
    end
    n.alertN = ~n.alert;
    n.overtN = ~|(n.ov & ~n.oMask);
    // Snapshot stands still until the link side has acknowledged it
    if (ackOk) begin
      n.snap = {c.hi, c.ov, c.flt, c.lo, c.wMask, c.oMask};
      n.snapReq = ~c.snapReq;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c <= CORE_RST;
    end else if (!rstSync) begin
      c <= CORE_RST;
      c.rstS <= {c.rstS[0], 1'b1};
    end else begin
      c <= n;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // Reads return the last snapshot, so a flag may lag by a few cycles
  always_comb begin
    ln = l;
    ln.rstS = {l.rstS[0], 1'b1};
    ln.reqS = {l.reqS[1:0], c.snapReq};
    if (regWrStb) begin
      ln.wrAddr = regAddr;
      ln.wrData = regWrData;
      ln.wrTgl = ~l.wrTgl;
    end
    if (regRdStb) begin
      ln.rdAddr = regAddr;
      ln.rdTgl = ~l.rdTgl;
    end
    if (araDone) begin
      ln.araTgl = ~l.araTgl;
    end
    if ((l.reqS[1] == l.reqS[2]) && (l.reqS[2] != l.ack)) begin
      ln.snap = c.snap;
      ln.ack = l.reqS[2];
    end
    case (regAddr)
      ADDR_WARN_MASK: ln.rdData = l.snap[SNAP_WM +: 8];
      ADDR_OVT_MASK: ln.rdData = l.snap[SNAP_OM +: 8];
      ADDR_HIGH_WARN: ln.rdData = l.snap[SNAP_HI +: 8];
      ADDR_OVERTEMP: ln.rdData = l.snap[SNAP_OV +: 8];
      ADDR_FAULT: ln.rdData = l.snap[SNAP_FLT +: 8];
      ADDR_LOW_WARN: ln.rdData = l.snap[SNAP_LO +: 8];
      default: ln.rdData = REG_RESET;
    endcase
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      l <= '0;
    end else if (!lrstSync) begin
      l <= '0;
      l.rstS <= {l.rstS[0], 1'b1};
    end else begin
      l <= ln;
    end
  end

  assign regRdData = l.rdData;
  assign alertN = c.alertN;
  assign overtN = c.overtN;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hiSet;
    @(posedge ref_clk) disable iff (!rstSync)
    hiViol && !softEv |=> c.hi[$past(hb)];
  endproperty
  a_hiSet: assert property (p_hiSet)
    else $error("high flag not set");

  property p_ovSet;
    @(posedge ref_clk) disable iff (!rstSync)
    ovViol && !softEv
      |=> c.ov[$past(ob)] && (!c.overtN || c.oMask[$past(ob)]);
  endproperty
  a_ovSet: assert property (p_ovSet)
    else $error("over flag or output not set");

  property p_fltSet;
    @(posedge ref_clk) disable iff (!rstSync)
    convValid && chFaulty && !softEv |=> c.flt[$past(convChan) - 3'h1];
  endproperty
  a_fltSet: assert property (p_fltSet)
    else $error("fault flag not set");

  property p_loSet;
    @(posedge ref_clk) disable iff (!rstSync)
    loViol && !softEv |=> c.lo[$past(hb)];
  endproperty
  a_loSet: assert property (p_loSet)
    else $error("low flag not set");

  property p_hiClr;
    @(posedge ref_clk) disable iff (!rstSync)
    rdEv && l.rdAddr == ADDR_HIGH_WARN && !convValid |=> c.hi == 8'h00;
  endproperty
  a_hiClr: assert property (p_hiClr)
    else $error("high flags kept after read");

  property p_araRel;
    @(posedge ref_clk) disable iff (!rstSync)
    araEv && !convValid |=> c.alertN ##1 c.alertN || $past(convValid);
  endproperty
  a_araRel: assert property (p_araRel)
    else $error("alert not released");

  property p_ovNoReadClr;
    @(posedge ref_clk) disable iff (!rstSync)
    rdEv && !convValid && !softEv && ovLimit == c.prevOvLim
      |=> c.ov == $past(c.ov);
  endproperty
  a_ovNoReadClr: assert property (p_ovNoReadClr)
    else $error("over flag changed on read");

  property p_overtPin;
    @(posedge ref_clk) disable iff (!rstSync)
    $stable(c.ov) && $stable(c.oMask) |-> c.overtN == ~|(c.ov & ~c.oMask);
  endproperty
  a_overtPin: assert property (p_overtPin)
    else $error("over output disagrees with flags");

  property p_softRst;
    @(posedge ref_clk) disable iff (!rstSync)
    softEv |=> (c.hi | c.lo | c.ov | c.flt) == 8'h00 && c.alertN;
  endproperty
  a_softRst: assert property (p_softRst)
    else $error("flags survive soft reset");

endmodule : tas_flags
`default_nettype wire

// ==== hw/tas_pkg.sv ====
// Register map, field layout and hysteresis constant of the temperature alarm flags
package tas_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h41;
  localparam logic [7:0] ADDR_WARN_MASK = 8'h42;
  localparam logic [7:0] ADDR_OVT_MASK = 8'h43;
  localparam logic [7:0] ADDR_HIGH_WARN = 8'h44;
  localparam logic [7:0] ADDR_OVERTEMP = 8'h45;
  localparam logic [7:0] ADDR_FAULT = 8'h46;
  localparam logic [7:0] ADDR_LOW_WARN = 8'h47;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_SWRST_BIT = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] CH_LOCAL = 3'h0;
  localparam logic [2:0] CH_TOP = 3'h7;
  localparam logic [2:0] HI_LOCAL_BIT = 3'h6;
  localparam logic [2:0] OV_LOCAL_BIT = 3'h7;
  localparam logic [8:0] HYST_DEGC = 9'h004;

  // Snapshot word handed to the link side
  localparam int SNAP_HI = 40;
  localparam int SNAP_OV = 32;
  localparam int SNAP_FLT = 24;
  localparam int SNAP_LO = 16;
  localparam int SNAP_WM = 8;
  localparam int SNAP_OM = 0;

  // ----------------------------------------------------------------
  // Bit positions of a channel
  // ----------------------------------------------------------------
  function automatic logic [2:0] hiPos(input logic [2:0] ch);
    if (ch == CH_LOCAL) begin
      return HI_LOCAL_BIT;
    end
    if (ch == CH_TOP) begin
      return CH_TOP;
    end
    return ch - 3'h1;
  endfunction : hiPos

  function automatic logic [2:0] ovPos(input logic [2:0] ch);
    if (ch == CH_LOCAL) begin
      return OV_LOCAL_BIT;
    end
    return ch - 3'h1;
  endfunction : ovPos

endpackage : tas_pkg

// ==== verification/tas_host_model.sv ====
// Host controller model driving the register port of the flags block
`timescale 1ns/1ps
`default_nettype none
module tas_host_model
  import tas_pkg::*;
(
  // Link clock
  input wire logic linkClk,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrStb,
  output logic [7:0] regWrData,
  output logic regRdStb,
  output logic araDone,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrStb = 1'b0;
    regWrData = 8'h00;
    regRdStb = 1'b0;
    araDone = 1'b0;
  end

  // ----------------------------------------------------------------
  // Strobes: kind 0 write, 1 clearing read, 2 alert response
  // ----------------------------------------------------------------
  // Four idle cycles after each strobe so two strobes never merge
  task automatic pulse(input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] k);
    @(negedge linkClk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= (k == 2'h0);
    regRdStb <= (k == 2'h1);
    araDone <= (k == 2'h2);
    @(negedge linkClk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    araDone <= 1'b0;
    regWrData <= ~d;
    repeat (4) @(negedge linkClk);
  endtask : pulse

  // Snapshot lags the core, so wait well past its worst case
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    @(negedge linkClk);
    regAddr <= a;
    repeat (30) @(negedge linkClk);
    d = regRdData;
  endtask : readReg
endmodule : tas_host_model
`default_nettype wire

// ==== verification/test_temp_alarm_status_flags.sv ====
// Self-checking bench of the temperature alarm status flags
`timescale 1ns/1ps
`default_nettype none
module test_temp_alarm_status_flags
  import tas_pkg::*;
;
  typedef struct {
    logic [2:0] ch;
    logic [7:0] t;
    logic f;
    logic [7:0] hi, ov, lo, fl;
  } tas_row_t;

  logic ref_clk, rst_b, linkClk, convValid, convFault;
  logic regWrStb, regRdStb, araDone, alertN, overtN;
  logic [2:0] convChan;
  logic [7:0] convTemp, regAddr, regWrData, regRdData;
  logic [63:0] hiLimit, loLimit, ovLimit;
  int failures = 0;
  int testsRun = 0;
  tas_row_t rows [9] = '{
    '{3'h0, 8'h65, 1'b0, 8'h40, 8'h00, 8'h00, 8'h00},
    '{3'h7, 8'h65, 1'b0, 8'h80, 8'h00, 8'h00, 8'h00},
    '{3'h1, 8'h65, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00},
    '{3'h0, 8'h79, 1'b0, 8'h40, 8'h80, 8'h00, 8'h00},
    '{3'h7, 8'h79, 1'b0, 8'h80, 8'h40, 8'h00, 8'h00},
    '{3'h3, 8'h13, 1'b0, 8'h00, 8'h00, 8'h04, 8'h00},
    '{3'h2, 8'h64, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00},
    '{3'h4, 8'h14, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00},
    '{3'h5, 8'hc8, 1'b1, 8'h00, 8'h00, 8'h00, 8'h10}};

  tas_flags tas_flags_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .convValid(convValid), .convChan(convChan), .convTemp(convTemp),
    .convFault(convFault), .hiLimit(hiLimit), .loLimit(loLimit),
    .ovLimit(ovLimit), .linkClk(linkClk), .regAddr(regAddr),
    .regWrStb(regWrStb), .regWrData(regWrData), .regRdStb(regRdStb),
    .araDone(araDone), .regRdData(regRdData), .alertN(alertN),
    .overtN(overtN));
  tas_host_model tas_host_model_i (.linkClk(linkClk), .regAddr(regAddr),
    .regWrStb(regWrStb), .regWrData(regWrData), .regRdStb(regRdStb),
    .araDone(araDone), .regRdData(regRdData));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : check

  task automatic conv(logic [2:0] c, logic [7:0] t, logic f);
    @(negedge ref_clk);
    convValid = 1'b1;
    convChan = c;
    convTemp = t;
    convFault = f;
    @(negedge ref_clk);
    convValid = 1'b0;
    convTemp = ~t;
    repeat (2) @(negedge ref_clk);
  endtask : conv

  task automatic rd(string n, logic [7:0] a, logic [7:0] e);
    logic [7:0] v;
    tas_host_model_i.readReg(a, v);
    check(n, e, v);
  endtask : rd

  task automatic bus(logic [7:0] a, logic [7:0] d, logic [1:0] k);
    tas_host_model_i.pulse(a, d, k);
    repeat (4) @(negedge ref_clk);
  endtask : bus

  // Bounded wait for both pins, then compare them
  task automatic pins(logic a, logic o);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (n < 100 && (alertN !== a || overtN !== o)) begin
      @(negedge ref_clk);
      n++;
    end
    check("alertN", {7'h00, a}, {7'h00, alertN});
    check("overtN", {7'h00, o}, {7'h00, overtN});
    if (n == 100) begin
      failures++;
      end_of_test();
    end
  endtask : pins

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {convValid, convFault, convChan, convTemp} = '0;
    hiLimit = {8{8'h64}};
    loLimit = {8{8'h14}};
    ovLimit = {8{8'h78}};
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    pins(1'b1, 1'b1);
    rd("hi", ADDR_HIGH_WARN, REG_RESET);
    rd("unmapped", 8'h50, 8'h00);
    for (int i = 0; i < 9; i++) begin
      conv(rows[i].ch, rows[i].t, rows[i].f);
      rd("hi", ADDR_HIGH_WARN, rows[i].hi);
      rd("ov", ADDR_OVERTEMP, rows[i].ov);
      rd("lo", ADDR_LOW_WARN, rows[i].lo);
      rd("flt", ADDR_FAULT, rows[i].fl);
      pins(~|(rows[i].hi | rows[i].lo), ~|rows[i].ov);
      bus(ADDR_CONFIG, 8'h40, 2'h0);
    end
    conv(3'h1, 8'h65, 1'b0);
    pins(1'b0, 1'b1);
    bus(ADDR_HIGH_WARN, 8'h00, 2'h1);
    pins(1'b1, 1'b1);
    rd("hi", ADDR_HIGH_WARN, 8'h00);
    conv(3'h1, 8'h65, 1'b0);
    pins(1'b0, 1'b1);
    bus(8'h00, 8'h00, 2'h2);
    pins(1'b1, 1'b1);
    rd("hi", ADDR_HIGH_WARN, 8'h01);
    bus(ADDR_HIGH_WARN, 8'h00, 2'h1);
    conv(3'h1, 8'h64, 1'b0);
    rd("hi", ADDR_HIGH_WARN, 8'h00);
    // Raising only this channel's limit ends its violation
    hiLimit[15:8] = 8'h66;
    conv(3'h1, 8'h65, 1'b0);
    rd("hi", ADDR_HIGH_WARN, 8'h00);
    // A low read clears its flags but keeps the alert latch
    conv(3'h3, 8'h13, 1'b0);
    rd("lo", ADDR_LOW_WARN, 8'h04);
    bus(ADDR_LOW_WARN, 8'h00, 2'h1);
    rd("lo", ADDR_LOW_WARN, 8'h00);
    pins(1'b0, 1'b1);
    conv(3'h0, 8'h79, 1'b0);
    bus(ADDR_OVERTEMP, 8'h00, 2'h1);
    conv(3'h0, 8'h74, 1'b0);
    rd("ov", ADDR_OVERTEMP, 8'h80);
    pins(1'b0, 1'b0);
    conv(3'h0, 8'h73, 1'b0);
    rd("ov", ADDR_OVERTEMP, 8'h00);
    pins(1'b0, 1'b1);
    conv(3'h2, 8'h79, 1'b0);
    ovLimit[23:16] = 8'h7c;
    rd("ov", ADDR_OVERTEMP, 8'h02);
    @(negedge ref_clk);
    ovLimit[23:16] = 8'h7d;
    rd("ov", ADDR_OVERTEMP, 8'h00);
    bus(ADDR_CONFIG, 8'h40, 2'h0);
    bus(ADDR_WARN_MASK, 8'h40, 2'h0);
    bus(ADDR_OVT_MASK, 8'h80, 2'h0);
    conv(3'h0, 8'h79, 1'b0);
    rd("hi", ADDR_HIGH_WARN, 8'h40);
    pins(1'b1, 1'b1);
    conv(3'h7, 8'h79, 1'b0);
    pins(1'b0, 1'b0);
    rst_b = 1'b0;
    repeat (4) @(negedge ref_clk);
    pins(1'b1, 1'b1);
    rst_b = 1'b1;
    rd("ov", ADDR_OVERTEMP, REG_RESET);
    end_of_test();
  end
endmodule : test_temp_alarm_status_flags
`default_nettype wire
